// ==== pkg/gprc_pkg.sv ====
/*
 holds the types shared by the port soft-reset block.
 assumes gprc_regs.svh is on the include path.
*/
`include "gprc_regs.svh"
package gprc_pkg;
   typedef logic [`GPRC_PORT_BITS-1:0] gprc_port_t;
   typedef logic [31:0] gprc_word_t;
   typedef logic [`GPRC_ADDR_W-1:0] gprc_addr_t;
endpackage

// ==== pkg/gprc_regs.svh ====
/*
 holds offsets, field positions, reset values and widths of the port soft-reset register.
 assumes a 32-bit apb slave with word-aligned registers.
*/
`ifndef GPRC_REGS_SVH
`define GPRC_REGS_SVH
`define GPRC_IO_PORT_SOFT_RESET_OFS 12'h048
`define GPRC_IO_PORT_SOFT_RESET_RST 32'h0000_0000
`define GPRC_PORT_BITS 8
`define GPRC_PORT_LSB 0
`define GPRC_PORT_MSB 7
`define GPRC_PRESENCE_DEFAULT 8'hff
`define GPRC_ADDR_W 12
`endif

// ==== rtl/gprc_port_bit.sv ====
/*
 holds one port reset bit with its presence gate.
 assumes a synchronous active-high system reset.
*/
module gprc_port_bit (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic wr_val,
   input wire logic present,
   output logic bit_q
);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bit_q <= 1'b0;
      end else if (wr_en && present) begin
         bit_q <= wr_val;
      end
   end
endmodule // gprc_port_bit

// ==== rtl/gprc_soft_reset.sv ====
/*
 holds the apb slave for the io port soft-reset register and the per-port reset outputs.
 assumes a single 40 MHz clock, synchronous active-high reset, and a static presence mask input.
*/
// Implementation choice: the APB register port.
// Behaviour
// - writes change a port bit only where its presence mask bit is set
// - eight read/write port reset bits, port a at bit 0 to h at 7
// - bits 31 to 8 read zero and ignore writes
// - system reset clears the whole register to zero
`include "gprc_regs.svh"
module gprc_soft_reset #(
   parameter int PORTS = `GPRC_PORT_BITS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire gprc_pkg::gprc_addr_t paddr,
   input wire gprc_pkg::gprc_word_t pwdata,
   input wire logic [3:0] pstrb,
   output gprc_pkg::gprc_word_t prdata,
   output logic pready,
   output logic pslverr,
   input wire gprc_pkg::gprc_port_t peripheral_presence_mask,
   output gprc_pkg::gprc_port_t port_reset
);
   import gprc_pkg::*;

   gprc_port_t bits;
   logic hit;
   logic wr_en;
   logic access_q;
   logic access_first;
   gprc_word_t rd_word;

   assign hit = (paddr == `GPRC_IO_PORT_SOFT_RESET_OFS);
   // first access cycle, the one that launches the answer
   assign access_first = psel && penable && !access_q;
   // low byte lane carries all port bits
   assign wr_en = psel && penable && pwrite && hit && pstrb[0] && access_q;
   assign rd_word = {{(32-PORTS){1'b0}}, bits};

   // one wait state keeps prdata and pready straight from flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         access_q <= 1'b0;
      end else begin
         access_q <= psel && penable && !access_q;
      end
   end

   for (genvar i = 0; i < PORTS; i++) begin : g_bit
      gprc_port_bit u_bit (
         .clk(clk),
         .sys_rst(sys_rst),
         .wr_en(wr_en),
         .wr_val(pwdata[i]),
         .present(peripheral_presence_mask[i]),
         .bit_q(bits[i])
      );

      property p_absent_frozen;
         @(posedge clk) disable iff (sys_rst)
         !peripheral_presence_mask[i] |=> $stable(bits[i]);
      endproperty
      a_absent_frozen: assert property (p_absent_frozen) else $error("absent port bit moved");

      property p_present_takes;
         @(posedge clk) disable iff (sys_rst)
         (wr_en && peripheral_presence_mask[i]) |=> (bits[i] == $past(pwdata[i]));
      endproperty
      a_present_takes: assert property (p_present_takes) else $error("present port bit missed write");
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access_first;
      end
   end

   // unmapped offsets answer with an error and leave the bits alone
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access_first && !hit;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= `GPRC_IO_PORT_SOFT_RESET_RST;
      end else if (access_first && !pwrite && hit) begin
         prdata <= rd_word;
      end else begin
         // zero outside the answer keeps stale data off the bus
         prdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         port_reset <= '0;
      end else begin
         port_reset <= bits;
      end
   end

   property p_masked_write;
      @(posedge clk) disable iff (sys_rst)
      wr_en |=> ((bits ^ $past(bits)) & ~$past(peripheral_presence_mask)) == '0;
   endproperty
   a_masked_write: assert property (p_masked_write) else $error("absent port bit changed");

   property p_write_takes;
      @(posedge clk) disable iff (sys_rst)
      wr_en |=> ((bits ^ $past(pwdata[7:0])) & $past(peripheral_presence_mask)) == '0;
   endproperty
   a_write_takes: assert property (p_write_takes) else $error("present port bit not written");

   property p_reserved_zero;
      @(posedge clk) disable iff (sys_rst)
      pready |-> (prdata[31:8] == 24'h000000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   property p_reset_clear;
      @(posedge clk) sys_rst |=> (bits == '0 && port_reset == '0);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

   sequence s_bits_change;
      !$stable(bits);
   endsequence
   property p_port_follows;
      @(posedge clk) disable iff (sys_rst)
      s_bits_change |=> (port_reset == $past(bits));
   endproperty
   a_port_follows: assert property (p_port_follows) else $error("port reset lags bits");

   property p_read_value;
      @(posedge clk) disable iff (sys_rst)
      (psel && penable && !access_q && !pwrite && hit) |=> (pready && prdata[7:0] == $past(bits));
   endproperty
   a_read_value: assert property (p_read_value) else $error("read data wrong");

   sequence s_first_access;
      access_first;
   endsequence
   sequence s_answer;
      pready;
   endsequence
   property p_one_wait;
      @(posedge clk) disable iff (sys_rst)
      s_first_access |-> !pready ##1 s_answer;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready timing wrong");

   property p_no_spurious;
      @(posedge clk) disable iff (sys_rst)
      !wr_en |=> $stable(bits);
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("bits changed without write");

   property p_ready_pulse;
      @(posedge clk) disable iff (sys_rst)
      s_answer |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");

   property p_error_flag;
      @(posedge clk) disable iff (sys_rst)
      (access_first && !hit) |=> (pready && pslverr && prdata == 32'h0000_0000);
   endproperty
   a_error_flag: assert property (p_error_flag) else $error("unmapped access not flagged");

   property p_hit_no_error;
      @(posedge clk) disable iff (sys_rst)
      (access_first && hit) |=> (pready && !pslverr);
   endproperty
   a_hit_no_error: assert property (p_hit_no_error) else $error("mapped access flagged");

   property p_unmapped_no_write;
      @(posedge clk) disable iff (sys_rst)
      (psel && penable && pwrite && !hit) |=> $stable(bits);
   endproperty
   a_unmapped_no_write: assert property (p_unmapped_no_write) else $error("unmapped write changed bits");

   property p_strobe_off;
      @(posedge clk) disable iff (sys_rst)
      (psel && penable && pwrite && !pstrb[0]) |=> $stable(bits);
   endproperty
   a_strobe_off: assert property (p_strobe_off) else $error("unstrobed write changed bits");

   property p_idle_zero;
      @(posedge clk) disable iff (sys_rst)
      !pready |-> (prdata == 32'h0000_0000 && !pslverr);
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("bus outputs not idle");

   property p_reset_outputs;
      @(posedge clk) sys_rst |=> (!pready && !pslverr && prdata == 32'h0000_0000);
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("bus outputs not cleared");

   property p_port_release;
      @(posedge clk) disable iff (sys_rst)
      (bits == '0) |=> (port_reset == '0);
   endproperty
   a_port_release: assert property (p_port_release) else $error("port not released");

   property p_port_tracks;
      @(posedge clk) disable iff (sys_rst)
      (bits != '0) |=> (port_reset == $past(bits));
   endproperty
   a_port_tracks: assert property (p_port_tracks) else $error("port reset not held");

   property p_write_in_access;
      @(posedge clk) disable iff (sys_rst)
      wr_en |-> pready;
   endproperty
   a_write_in_access: assert property (p_write_in_access) else $error("write outside answer edge");

   property p_read_keeps;
      @(posedge clk) disable iff (sys_rst)
      (access_first && !pwrite) |=> $stable(bits);
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("read changed bits");
endmodule // gprc_soft_reset

// ==== sim/gprc_soft_reset_test.sv ====
/*
 self-checking bench for the io port soft-reset register.
 assumes gprc_pkg is compiled first; drives apb and the presence mask itself.
*/
module gprc_soft_reset_test;
   timeunit 1ns;
   timeprecision 1ps;
   import gprc_pkg::*;
   logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic [3:0] pstrb = '0, s;
   gprc_addr_t paddr = '0, a;
   gprc_word_t pwdata = '0, prdata, rd, d, r;
   logic pready, pslverr;
   gprc_port_t mask = 8'hff, port_reset, m = '0;
   int err_total = 0, compares = 0;
   logic [31:0] rng = 32'h10;
   gprc_soft_reset u_gprc_soft_reset(.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .peripheral_presence_mask(mask), .port_reset(port_reset));
   initial forever #12.5 clk = ~clk;
   function logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // only present ports take the written value
   function gprc_port_t upd(gprc_port_t o, gprc_port_t pm, gprc_word_t w);
      return (o & ~pm) | (w[7:0] & pm);
   endfunction
   task chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   // waits for pready, since the slave sets its own latency
   task apb(logic w, gprc_addr_t ad, gprc_word_t wd, logic [3:0] st);
      int i;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      pstrb <= st;
      @(posedge clk);
      penable <= 1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1);
      chk("pready_wait", 2, i);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task results();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      err_total++;
      results();
   end
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 0;
      apb(0, 12'h048, 0, 4'h0);
      chk("rst_rd", 0, rd);
      for (int k = 0; k < 60; k++) begin
         r = xs();
         mask <= (k < 3) ? 8'hff : r[7:0];
         d = (k == 1) ? 32'hffff_ffff : xs();
         if (k % 3 == 2) d = {rd[31:8], d[7:0]};
         s = (k % 5 == 4) ? 4'he : 4'hf;
         a = (k % 7 == 6) ? 12'h04c : 12'h048;
         apb(1, a, d, s);
         if (a == 12'h048 && s[0]) m = upd(m, mask, d);
         chk("wr_err", {31'h0, a != 12'h048}, {31'h0, er});
         apb(0, 12'h048, 0, 4'h0);
         chk("rd", {24'h0, m}, rd);
         chk("port_reset", {24'h0, m}, {24'h0, port_reset});
      end
      mask <= 8'hff;
      apb(1, 12'h048, 32'h0000_00a5, 4'h1);
      apb(0, 12'h048, 0, 4'h0);
      chk("pre_rst_port", 32'h0000_00a5, {24'h0, port_reset});
      @(posedge clk);
      sys_rst <= 1;
      repeat (2) @(posedge clk);
      sys_rst <= 0;
      apb(0, 12'h048, 0, 4'h0);
      chk("rst2_rd", 0, rd);
      chk("rst2_port", 0, {24'h0, port_reset});
      results();
   end
endmodule // gprc_soft_reset_test
